// ==== hdl/idle_powerdown_mode_control.sv ====
// Purpose: idle and power-down mode controller for an 8-bit core
// Assumes: core presents power control writes as a one-cycle strobe with data
// Notes:   clock gating outputs are enables; core and peripherals gate on them
// Behaviour
// - instruction setting idle request is the last executed before idle.
// - idle stops cpu clock, keeps interrupt, timer and serial clocks running.
// - cpu registers hold their contents during idle.
// - idle holds port pins and drives both strobes high.
// - enabled interrupt in idle clears idle bit, services, resumes after.
// - two general flags written together with the idle request.
// - reset held two machine cycles (24 periods) ends idle.
// - power-down request stops oscillator after the requesting instruction.
// - ram and special registers keep values through power-down.
// - power-down ends only by hardware reset or external interrupt.
// - only the two enabled external interrupt lines wake power-down.
// - enabled line low restarts oscillator, line high completes exit.
// - both enabled: either low restarts, first release exits.
// - after service, resume after the power-down instruction.
// - reset exit reinitialises registers; interrupt exit leaves them; ram kept.
// - both requests set: power-down exit, both bits cleared, no idle.
// - power-down strobes low; external memory port0 floats, port2 per mode.
// - held port0 drives zeros only, ones float.
// - source enabled only with global enable and its own enable set.
`timescale 1ns/1ps
module idle_powerdown_mode_control
	import ipmc_pkg::*;
#(
	parameter int RESET_HOLD = ipmc_pkg::RESET_HOLD_CYC,
	parameter int OSC_START  = ipmc_pkg::OSC_START_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       pconWrite,
	input  wire logic [7:0] pconWriteData,
	input  wire logic       instrRetire,
	input  wire logic       globalInterruptEnable,
	input  wire logic [5:0] sourceEnable,
	input  wire logic [5:0] sourceRequest,
	input  wire logic       irqZeroHighPriority,
	input  wire logic       irqOneHighPriority,
	input  wire logic       externalIrqLineZero,
	input  wire logic       externalIrqLineOne,
	input  wire logic       hwResetPin,
	input  wire logic       externalProgram,
	input  wire logic [7:0] port0Data,
	input  wire logic [7:0] port2Data,
	input  wire logic [7:0] port2Address,
	output logic [7:0]      powerControlRegister,
	output logic            cpuClockEnable,
	output logic            periphClockEnable,
	output logic            oscillatorEnable,
	output logic            registerHold,
	output logic            sfrReinit,
	output logic            wakeVector,
	output logic [1:0]      wakeSource,
	output logic            addressLatchStrobe,
	output logic            programStoreStrobe,
	output logic            strobeOverride,
	output logic            portFreeze,
	output logic [7:0]      port0Out,
	output logic [7:0]      port0OutEnable,
	output logic [7:0]      port2Out,
	output logic            port2Override
);
	import ipmc_pkg::*;

	initial begin
		if (RESET_HOLD < 1 || OSC_START < 1) begin
			$error("idle_powerdown_mode_control counts must be at least one");
		end
	end

	localparam int OW = $clog2(OSC_START + 1);

	ipmc_mode_type mode;
	ipmc_mode_type next_mode;
	logic          irqZeroSync;
	logic          irqOneSync;
	logic          resetSync;
	logic          resetDone;
	logic          pendingIdle;
	logic          pendingPdown;
	logic          anyEnabledIrq;
	logic          extZeroArmed;
	logic          extOneArmed;
	logic          extLow;
	logic [OW-1:0] oscCount;
	logic          oscStable;
	logic [7:0]    port0Held;
	logic [7:0]    port2Held;

	ipmc_sync #(.WIDTH(3), .RESETVAL(1'b1)) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({externalIrqLineZero, externalIrqLineOne, ~hwResetPin}),
		.syncOut ({irqZeroSync, irqOneSync, resetSync})
	);

	ipmc_reset_filter #(.HOLD(RESET_HOLD)) u_rstf (
		.clk        (clk),
		.rst_n      (rst_n),
		.resetLevel (~resetSync),
		.resetDone  (resetDone)
	);

	// enable qualification
	assign anyEnabledIrq = globalInterruptEnable && |(sourceEnable & sourceRequest);
	assign extZeroArmed  = globalInterruptEnable && sourceEnable[0];
	assign extOneArmed   = globalInterruptEnable && sourceEnable[2];
	assign extLow        = (extZeroArmed && !irqZeroSync) || (extOneArmed && !irqOneSync);

	// request latched on write, mode entered when that instruction retires
	always_ff @(posedge clk) begin
		if (!rst_n || resetDone) begin
			pendingIdle  <= 1'b0;
			pendingPdown <= 1'b0;
		end else if (pconWrite) begin
			pendingIdle  <= pconWriteData[IDLE_BIT];
			pendingPdown <= pconWriteData[PDOWN_BIT];
		end else if (instrRetire) begin
			pendingIdle  <= 1'b0;
			pendingPdown <= 1'b0;
		end
	end

	always_comb begin
		next_mode = mode;
		unique case (mode)
			IPMC_RUN: begin
				if (instrRetire && pendingPdown) begin
					next_mode = IPMC_PDOWN;
				end else if (instrRetire && pendingIdle) begin
					next_mode = IPMC_IDLE;
				end
			end
			IPMC_IDLE: begin
				if (anyEnabledIrq) begin
					next_mode = IPMC_RUN;
				end
			end
			IPMC_PDOWN: begin
				if (extLow) begin
					next_mode = IPMC_WAKE;
				end
			end
			IPMC_WAKE: begin
				if (oscStable && (irqZeroSync || !extZeroArmed) && (irqOneSync || !extOneArmed)) begin
					next_mode = IPMC_RUN;
				end else if (oscStable && ((extZeroArmed && irqZeroSync) || (extOneArmed && irqOneSync))) begin
					next_mode = IPMC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n || resetDone) begin
			mode <= IPMC_RUN;
		end else begin
			mode <= next_mode;
		end
	end

	// oscillator restart settling
	always_ff @(posedge clk) begin
		if (!rst_n || mode != IPMC_WAKE) begin
			oscCount <= '0;
		end else if (oscCount != OW'(OSC_START)) begin
			oscCount <= oscCount + OW'(1);
		end
	end
	assign oscStable = (oscCount == OW'(OSC_START));

	// power control register with flags and hardware clear
	always_ff @(posedge clk) begin
		if (!rst_n || resetDone) begin
			powerControlRegister <= POWER_CONTROL_REGISTER_RESET;
		end else if ((mode == IPMC_IDLE || mode == IPMC_WAKE) && next_mode == IPMC_RUN) begin
			powerControlRegister[IDLE_BIT]  <= 1'b0;
			powerControlRegister[PDOWN_BIT] <= 1'b0;
		end else if (pconWrite) begin
			powerControlRegister <= pconWriteData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cpuClockEnable    <= 1'b1;
			periphClockEnable <= 1'b1;
			oscillatorEnable  <= 1'b1;
			registerHold      <= 1'b0;
		end else begin
			cpuClockEnable    <= (next_mode == IPMC_RUN);
			periphClockEnable <= (next_mode != IPMC_PDOWN);
			oscillatorEnable  <= (next_mode != IPMC_PDOWN);
			registerHold      <= (next_mode != IPMC_RUN);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sfrReinit  <= 1'b0;
			wakeVector <= 1'b0;
			wakeSource <= 2'b00;
		end else begin
			sfrReinit  <= resetDone;
			wakeVector <= (mode == IPMC_WAKE) && (next_mode == IPMC_RUN);
			if (mode == IPMC_WAKE && next_mode == IPMC_RUN) begin
				if (extZeroArmed && extOneArmed) begin
					wakeSource <= (irqOneHighPriority && !irqZeroHighPriority) ? 2'b10 : 2'b01;
				end else begin
					wakeSource <= {extOneArmed, extZeroArmed};
				end
			end
		end
	end

	// strobe levels per mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addressLatchStrobe <= 1'b1;
			programStoreStrobe <= 1'b1;
			strobeOverride     <= 1'b0;
		end else begin
			addressLatchStrobe <= (next_mode == IPMC_IDLE);
			programStoreStrobe <= (next_mode == IPMC_IDLE);
			strobeOverride     <= (next_mode != IPMC_RUN);
		end
	end

	// port capture at entry
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port0Held <= 8'h00;
			port2Held <= 8'h00;
		end else if (mode == IPMC_RUN && next_mode != IPMC_RUN) begin
			port0Held <= port0Data;
			port2Held <= port2Data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			portFreeze     <= 1'b0;
			port0Out       <= 8'h00;
			port0OutEnable <= 8'h00;
			port2Out       <= 8'h00;
			port2Override  <= 1'b0;
		end else if (mode != IPMC_RUN) begin
			portFreeze     <= 1'b1;
			port0Out       <= 8'h00;
			port0OutEnable <= externalProgram ? 8'h00 : ~port0Held;
			port2Out       <= (externalProgram && mode == IPMC_IDLE) ? port2Address : port2Held;
			port2Override  <= 1'b1;
		end else begin
			portFreeze     <= 1'b0;
			port0Out       <= 8'h00;
			port0OutEnable <= 8'h00;
			port2Out       <= 8'h00;
			port2Override  <= 1'b0;
		end
	end

	sequence s_pdown_enter;
		(mode == IPMC_RUN) && instrRetire && pendingPdown;
	endsequence

	a_pdown_entry: assert property (@(posedge clk) disable iff (!rst_n)
		(s_pdown_enter and !resetDone) |=> mode == IPMC_PDOWN && !oscillatorEnable)
		else $error("power-down not entered after request");
	a_idle_entry: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == IPMC_RUN) && instrRetire && pendingIdle && !pendingPdown && !resetDone
		|=> mode == IPMC_IDLE && !cpuClockEnable && periphClockEnable)
		else $error("idle entry wrong");
	a_idle_strobes: assert property (@(posedge clk) disable iff (!rst_n)
		mode == IPMC_IDLE && $past(mode) == IPMC_IDLE |-> addressLatchStrobe && programStoreStrobe)
		else $error("strobes not high in idle");
	a_pdown_strobes: assert property (@(posedge clk) disable iff (!rst_n)
		mode == IPMC_PDOWN && $past(mode) == IPMC_PDOWN |-> !addressLatchStrobe && !programStoreStrobe)
		else $error("strobes not low in power-down");
	a_idle_wake: assert property (@(posedge clk) disable iff (!rst_n)
		mode == IPMC_IDLE && anyEnabledIrq && !resetDone
		|=> mode == IPMC_RUN && !powerControlRegister[IDLE_BIT])
		else $error("idle not ended by interrupt");
	a_pdown_only_ext: assert property (@(posedge clk) disable iff (!rst_n)
		mode == IPMC_PDOWN && !extLow && !resetDone |=> mode == IPMC_PDOWN)
		else $error("power-down left without cause");
	a_reset_exit: assert property (@(posedge clk) disable iff (!rst_n)
		resetDone |=> mode == IPMC_RUN && powerControlRegister == POWER_CONTROL_REGISTER_RESET && sfrReinit)
		else $error("reset exit wrong");
	a_port0_zeros: assert property (@(posedge clk) disable iff (!rst_n)
		portFreeze |-> (port0OutEnable & ~port0Out) == port0OutEnable)
		else $error("port0 drives a one while held");
	a_wake_clears: assert property (@(posedge clk) disable iff (!rst_n)
		wakeVector |-> !powerControlRegister[IDLE_BIT] && !powerControlRegister[PDOWN_BIT])
		else $error("request bits not cleared on wake");
endmodule : idle_powerdown_mode_control

// ==== hdl/ipmc_pkg.sv ====
// Purpose: shared constants for the idle / power-down mode controller
// Assumes: 8-bit core, power control register bit layout below
// Notes:   timing counts in oscillator periods of clk
package ipmc_pkg;
	localparam int          IDLE_BIT      = 0;
	localparam int          PDOWN_BIT     = 1;
	localparam int          GF0_BIT       = 2;
	localparam int          GF1_BIT       = 3;
	localparam logic [7:0]  POWER_CONTROL_REGISTER_RESET    = 8'h00;
	localparam int          RESET_HOLD_OSC = 24;
	localparam int          CLK_PERIOD_NS = 8;
	localparam int          RESET_HOLD_NS = RESET_HOLD_OSC * CLK_PERIOD_NS;
	localparam int          RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          OSC_START_CYC = 16;
	typedef enum logic [1:0] {
		IPMC_RUN,
		IPMC_IDLE,
		IPMC_PDOWN,
		IPMC_WAKE
	} ipmc_mode_type;
endpackage : ipmc_pkg

// ==== hdl/ipmc_sync.sv ====
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: single clock clk, synchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ipmc_sync #(
	parameter int          WIDTH    = 1,
	parameter logic        RESETVAL = 1'b1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stageOne;
	initial begin
		if (WIDTH < 1) begin
			$error("ipmc_sync width must be positive");
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stageOne <= {WIDTH{RESETVAL}};
			syncOut  <= {WIDTH{RESETVAL}};
		end else begin
			stageOne <= asyncIn;
			syncOut  <= stageOne;
		end
	end
endmodule : ipmc_sync

// ==== hdl/ipmc_reset_filter.sv ====
// Purpose: qualifies the pin reset, demanding a minimum hold time
// Assumes: pin already synchronised, active high request
// Notes:   pulse shorter than HOLD cycles is ignored
`timescale 1ns/1ps
module ipmc_reset_filter #(
	parameter int HOLD = 24
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic resetLevel,
	output logic      resetDone
);
	localparam int CW = $clog2(HOLD + 1);
	logic [CW-1:0] holdCount;
	initial begin
		if (HOLD < 1) begin
			$error("ipmc_reset_filter hold must be at least one");
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			holdCount <= '0;
		end else if (!resetLevel) begin
			holdCount <= '0;
		end else if (holdCount != CW'(HOLD)) begin
			holdCount <= holdCount + CW'(1);
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resetDone <= 1'b0;
		end else begin
			resetDone <= resetLevel && (holdCount == CW'(HOLD - 1));
		end
	end
endmodule : ipmc_reset_filter

// ==== sim/ipmc_pin_model.sv ====
// Purpose: far-side pins, external interrupt lines and hardware reset pin
// Assumes: interrupt lines pulled up, reset pin idle low
// Notes:   every change lands on a falling clk edge
`timescale 1ns/1ps
module ipmc_pin_model (
	input  wire logic clk,
	output logic      irqZero,
	output logic      irqOne,
	output logic      resetPin
);
	initial begin
		irqZero  = 1'b1;
		irqOne   = 1'b1;
		resetPin = 1'b0;
	end
	// pull a line low and keep it low until let_go
	task automatic press(input int w);
		@(negedge clk);
		if (w == 0) irqZero = 1'b0;
		else irqOne = 1'b0;
	endtask : press
	task automatic let_go(input int w);
		@(negedge clk);
		if (w == 0) irqZero = 1'b1;
		else irqOne = 1'b1;
	endtask : let_go
	// reset held for n cycles, waker decides how long
	task automatic rst_pulse(input int n);
		@(negedge clk);
		resetPin = 1'b1;
		repeat (n) @(negedge clk);
		resetPin = 1'b0;
	endtask : rst_pulse
endmodule : ipmc_pin_model

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the idle / power-down controller
// Assumes: inputs driven on falling edges, outputs sampled there
// Notes:   oscillator start count shortened to OSC cycles
`timescale 1ns/1ps
`define CHK(a, b) cmp(8'(a), 8'(b))
module testbench;
	import ipmc_pkg::*;
	localparam int OSC = 4;
	logic       clk, rstN, pconWrite, instrRetire, gie, extProg;
	logic [7:0] pconData, p0Data, p2Data, p2Addr, power_control_register, p0Out, p0Oe, p2Out;
	logic [5:0] srcEn, srcReq;
	logic       irq0, irq1, rstPin, cpuEn, perEn, oscEn, hold, reinit, wakeVec;
	logic       ale, pse, freeze;
	logic       prio0, prio1, strOvr, p2Ovr;
	logic [1:0] wakeSrc;
	int         err_count, check_count;
	ipmc_pin_model i_ipmc_pin_model (.clk(clk), .irqZero(irq0), .irqOne(irq1), .resetPin(rstPin));
	idle_powerdown_mode_control #(.OSC_START(OSC)) i_idle_powerdown_mode_control (
		.clk(clk), .rst_n(rstN), .pconWrite(pconWrite), .pconWriteData(pconData),
		.instrRetire(instrRetire), .globalInterruptEnable(gie), .sourceEnable(srcEn),
		.sourceRequest(srcReq), .irqZeroHighPriority(prio0), .irqOneHighPriority(prio1),
		.externalIrqLineZero(irq0), .externalIrqLineOne(irq1), .hwResetPin(rstPin),
		.externalProgram(extProg), .port0Data(p0Data), .port2Data(p2Data), .port2Address(p2Addr),
		.powerControlRegister(power_control_register), .cpuClockEnable(cpuEn), .periphClockEnable(perEn),
		.oscillatorEnable(oscEn), .registerHold(hold), .sfrReinit(reinit), .wakeVector(wakeVec),
		.wakeSource(wakeSrc), .addressLatchStrobe(ale), .programStoreStrobe(pse),
		.strobeOverride(strOvr), .portFreeze(freeze), .port0Out(p0Out), .port0OutEnable(p0Oe),
		.port2Out(p2Out), .port2Override(p2Ovr)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic waitv(ref logic s, input logic v, input int n);
		for (int i = 0; i < n && s !== v; i++) @(negedge clk);
		`CHK(s, v);
	endtask : waitv
	// write the register, retire two cycles after the write strobe, then wait three cycles
	task automatic power_control_register_wr(input logic [7:0] d);
		@(negedge clk);
		pconWrite = 1'b1;
		pconData  = d;
		@(negedge clk);
		pconWrite = 1'b0;
		@(negedge clk);
		`CHK(cpuEn, 1'b1);
		instrRetire = 1'b1;
		@(negedge clk);
		instrRetire = 1'b0;
		repeat (3) @(negedge clk);
	endtask : power_control_register_wr
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end
	initial begin
		{rstN, pconWrite, instrRetire, gie, extProg} = 5'b0_0000;
		{pconData, srcEn, srcReq} = 20'h0_0000;
		{prio0, prio1} = 2'b10;
		p0Data = 8'hA5;
		p2Data = 8'h3C;
		p2Addr = 8'hC3;
		err_count = 0;
		check_count = 0;
		repeat (6) @(negedge clk);
		rstN = 1'b1;
		`CHK(power_control_register, POWER_CONTROL_REGISTER_RESET);
		`CHK({cpuEn, perEn, oscEn, ale, pse, freeze}, 6'h3E);
		`CHK({strOvr, p2Ovr}, 2'h0);
		$display("test reset done");
		power_control_register_wr(8'h0D);
		`CHK(power_control_register, 8'h0D);
		`CHK({cpuEn, perEn, oscEn, ale, pse, hold}, 6'h1F);
		`CHK({strOvr, p2Ovr}, 2'h3);
		p0Data = 8'h00;
		repeat (2) @(negedge clk);
		`CHK(p0Oe, 8'h5A);
		`CHK(p0Out & p0Oe, 8'h00);
		{gie, srcEn, srcReq} = 13'h1_082;
		waitv(cpuEn, 1'b1, 10);
		`CHK(power_control_register, 8'h0C);
		srcReq = 6'h00;
		$display("test idle irq done");
		gie = 1'b0;
		extProg = 1'b1;
		power_control_register_wr(8'h01);
		srcReq = 6'h02;
		p2Addr = 8'h69;
		repeat (5) @(negedge clk);
		`CHK(cpuEn, 1'b0);
		`CHK(p2Out, p2Addr);
		`CHK(p0Oe, 8'h00);
		i_ipmc_pin_model.rst_pulse(10);
		repeat (8) @(negedge clk);
		`CHK(cpuEn, 1'b0);
		i_ipmc_pin_model.rst_pulse(30);
		waitv(cpuEn, 1'b1, 10);
		`CHK(power_control_register, 8'h00);
		srcReq = 6'h00;
		$display("test idle reset done");
		gie = 1'b1;
		p2Data = 8'h96;
		power_control_register_wr(8'h02);
		`CHK({oscEn, ale, pse, freeze}, 4'h1);
		`CHK(p2Out, p2Data);
		p2Data = 8'h00;
		srcReq = 6'h02;
		i_ipmc_pin_model.press(1);
		repeat (10) @(negedge clk);
		`CHK(oscEn, 1'b0);
		`CHK(p2Out, 8'h96);
		i_ipmc_pin_model.let_go(1);
		srcReq = 6'h00;
		srcEn = 6'h01;
		i_ipmc_pin_model.press(0);
		waitv(oscEn, 1'b1, 8);
		`CHK({power_control_register, hold}, 9'h005);
		repeat (OSC + 2) @(negedge clk);
		`CHK(wakeVec, 1'b0);
		i_ipmc_pin_model.let_go(0);
		waitv(wakeVec, 1'b1, 10);
		`CHK({wakeSrc, power_control_register, reinit}, 11'h200);
		$display("test powerdown irq done");
		srcEn = 6'h05;
		{prio0, prio1} = 2'b01;
		power_control_register_wr(8'h03);
		`CHK({cpuEn, oscEn}, 2'h0);
		i_ipmc_pin_model.press(0);
		i_ipmc_pin_model.press(1);
		repeat (OSC + 6) @(negedge clk);
		i_ipmc_pin_model.let_go(1);
		waitv(wakeVec, 1'b1, 10);
		`CHK({wakeSrc, power_control_register}, 10'h200);
		waitv(cpuEn, 1'b1, 4);
		i_ipmc_pin_model.let_go(0);
		$display("test both bits done");
		power_control_register_wr(8'h02);
		fork
			i_ipmc_pin_model.rst_pulse(30);
			waitv(reinit, 1'b1, 40);
		join
		`CHK({power_control_register, oscEn}, 9'h001);
		$display("test powerdown reset done");
		stop_test();
	end
endmodule : testbench
